// ### src/tdm_sys_consts.vh
// Purpose: shared constants of the per-transceiver system-side serial interface
// Assumes: 32-bit register words at byte addresses, 10 MHz core clock
// Notes: the behaviour list below is kept in step with the tags in the code
//
// Behaviour
// R1: transmit data sampled on falling line clock, or falling system clock with elastic store on.
// R2: outside party supplies an 8.192MHz transmit system clock when transmit elastic store is on.
// R3: transmit system sync used only with elastic store on; its pulse starts a frame.
// R4: outside party holds transmit system sync low when the elastic store is unused.
// R5: line transmit clock is 1.544 or 2.048MHz and clocks the transmit formatter; with elastic store on the code clocks it from the system clock.
// R6: channel block output follows a programmed per-channel mask, timed by the selected clock.
// R7: channel clock pulses high during each channel LSB, timed by the selected clock.
// R8: channel clock can instead give a gated bit clock for fractional channels.
// R9: transmit sync pin is bidirectional; input sets boundary, output gives frame or multiframe pulse.
// R10: in T1 frame-pulse mode a control bit selects double-wide pulses on signaling frames.
// R11: signaling input sampled like serial data and inserted into the outgoing stream.
// R12: mapper serial output launches each bit on the rising mapper transmit clock.
// R13: mapper byte sync pulse marks the first channel 1 slot of the interleaved stream.
// R14: in X.86 mode the mapper also takes its byte alignment from the byte sync input; the code realigns only the bit count there.
// R15: receive serial data changes on rising receive system clock with receive elastic store on.
// R16: outside logic joins the four receive serial outputs into the mapper receive input.
// R17: outside party supplies an 8.192MHz receive system clock when receive elastic store is on.
// R18: outside logic joins the four receive system clocks onto the mapper receive clock.
// R19: separate settings enable transmit and receive elastic stores and pick each side's clock.
`ifndef TDM_SYS_CONSTS_VH
`define TDM_SYS_CONSTS_VH

// register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_BLOCK 8'h04
`define ADDR_FRAC 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_TXBYTE 8'h10

// control register fields
`define CTRL_TX_ES 0
`define CTRL_RX_ES 1
`define CTRL_E1 2
`define CTRL_GATED 3
`define CTRL_SYNC_OUT 4
`define CTRL_SYNC_MF 5
`define CTRL_DOUBLE_WIDE 6
`define CTRL_SIG_EN 7
`define CTRL_X86 8
`define CTRL_SLOT_LO 9
`define CTRL_SLOT_HI 10
`define CTRL_WIDTH 11
`define CTRL_RESET 11'h000
`define MASK_RESET 32'h0000_0000

// status register fields
`define STAT_UNDERRUN 0

// frame and mapper timing, in bits, frames, channels and bytes
`define T1_FRAME_LAST 9'h0C0
`define E1_FRAME_LAST 9'h0FF
`define T1_MF_LAST 4'hB
`define E1_MF_LAST 4'hF
`define T1_SIG_FRAME_A 4'h5
`define T1_SIG_FRAME_B 4'hB
`define E1_SIG_CHANNEL 5'h10
`define MAP_BYTE_LAST 10'h3FF
`define RX_IDLE_BYTE 8'hFF

`endif

// ### src/edge_sync.v
// Purpose: two-stage synchroniser with edge detection for a group of pins
// Assumes: inputs are asynchronous to clk and slower than half its rate
// Notes: stage one feeds only stage two
`timescale 1ns/1ns
module edge_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // pins
  input wire [W-1:0] pin,
  // synchronised level and edges
  output wire [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg meta_r;
      reg sync_r;
      reg prev_r;
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
        end
        else
        begin
          meta_r <= pin[i];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end
      assign level[i] = sync_r;
      assign rise[i] = sync_r & ~prev_r;
      assign fall[i] = ~sync_r & prev_r;
    end
  endgenerate
endmodule // edge_sync

// ### src/byte_buffer2.v
// Purpose: two-entry byte buffer with valid and ready on both sides
// Assumes: single clock domain
// Notes: in_ready comes from a flop
`timescale 1ns/1ns
module byte_buffer2 (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data
);
  reg [7:0] mem_r [0:1];
  reg rd_ptr_r;
  reg wr_ptr_r;
  reg [1:0] count_r;
  reg not_full_r;
  wire push;
  wire pop;
  wire [1:0] count_nxt;

  assign push = in_valid & not_full_r;
  assign pop = out_ready & (count_r != 2'h0);
  assign count_nxt = (push & ~pop) ? count_r + 2'h1 : ((pop & ~push) ? count_r - 2'h1 : count_r);
  assign in_ready = not_full_r;
  assign out_valid = (count_r != 2'h0);
  assign out_data = mem_r[rd_ptr_r];

  always @(posedge clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      count_r <= 2'h0;
      not_full_r <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ~wr_ptr_r;
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      count_r <= count_nxt;
      not_full_r <= (count_nxt != 2'h2);
    end
  end
endmodule // byte_buffer2

// ### src/tdm_system_side_interface.v
// Purpose: system-side serial interface of one framer transceiver and the mapper transmit port
// Assumes: all serial clocks are sampled by clk and run below a quarter of its rate
// Notes: serial outputs change at the detected clock edge, about three clk cycles after the pin edge
`timescale 1ns/1ns
`include "tdm_sys_consts.vh"
module tdm_system_side_interface (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // transmit framer pins
  input wire tx_line_clock,
  input wire tx_system_clock,
  input wire tx_serial_in,
  input wire tx_signaling_in,
  input wire tx_system_sync,
  output reg tx_channel_block,
  output reg tx_channel_clock,
  // transmit sync two-way pin
  input wire tx_frame_sync_in,
  output reg tx_frame_sync_out,
  output reg tx_frame_sync_oe,
  // mapper transmit pins
  input wire mapper_tx_clock,
  input wire mapper_tx_byte_sync,
  output reg mapper_tx_serial_out,
  // receive framer pins
  input wire rx_system_clock,
  output reg rx_serial_out,
  // receive byte source
  input wire rx_byte_valid,
  output wire rx_byte_ready,
  input wire [7:0] rx_byte_data
);
  localparam S_LCLK = 0;
  localparam S_SYSCLK = 1;
  localparam S_MAPCLK = 2;
  localparam S_RXCLK = 3;
  localparam S_SER = 4;
  localparam S_SIG = 5;
  localparam S_SSYNC = 6;
  localparam S_FSYNC = 7;
  localparam S_BSYNC = 8;

  wire [8:0] s_lvl;
  wire [8:0] s_rise;
  wire [8:0] s_fall;

  edge_sync #(.W(9)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin({mapper_tx_byte_sync, tx_frame_sync_in, tx_system_sync, tx_signaling_in, tx_serial_in,
          rx_system_clock, mapper_tx_clock, tx_system_clock, tx_line_clock}),
    .level(s_lvl),
    .rise(s_rise),
    .fall(s_fall)
  );

  // configuration
  reg [`CTRL_WIDTH-1:0] ctrl_r;
  reg [31:0] block_mask_r;
  reg [31:0] frac_mask_r;
  reg underrun_r;
  wire tx_es = ctrl_r[`CTRL_TX_ES];
  wire rx_es = ctrl_r[`CTRL_RX_ES];
  wire e1 = ctrl_r[`CTRL_E1];
  wire gated = ctrl_r[`CTRL_GATED];
  wire sync_out = ctrl_r[`CTRL_SYNC_OUT];
  wire sync_mf = ctrl_r[`CTRL_SYNC_MF];
  wire double_wide_sync_select = ctrl_r[`CTRL_DOUBLE_WIDE];
  wire sig_en = ctrl_r[`CTRL_SIG_EN];
  wire x86 = ctrl_r[`CTRL_X86];
  wire [1:0] slot = ctrl_r[`CTRL_SLOT_HI:`CTRL_SLOT_LO];

  // transmit timing source
  wire tx_clk_lvl = tx_es ? s_lvl[S_SYSCLK] : s_lvl[S_LCLK]; // R19
  wire tx_rise = tx_es ? s_rise[S_SYSCLK] : s_rise[S_LCLK]; // R5
  wire tx_fall = tx_es ? s_fall[S_SYSCLK] : s_fall[S_LCLK]; // R1

  // transmit frame position
  reg [8:0] pos_r;
  reg [3:0] frame_r;
  reg sync_pend_r;
  wire [8:0] ch_pos = e1 ? pos_r : pos_r - 9'h001;
  wire fbit = ~e1 & (pos_r == 9'h000);
  wire [4:0] chan = ch_pos[7:3];
  wire lsb = (ch_pos[2:0] == 3'h7) & ~fbit;
  wire [8:0] frame_last = e1 ? `E1_FRAME_LAST : `T1_FRAME_LAST; // R5
  wire [3:0] mf_last = e1 ? `E1_MF_LAST : `T1_MF_LAST;
  wire sig_frame = (frame_r == `T1_SIG_FRAME_A) | (frame_r == `T1_SIG_FRAME_B);
  // an input pulse only counts from the pin that is in input mode for the current setting
  wire ssync_hit = tx_es & s_rise[S_SSYNC]; // R3
  wire fsync_hit = ~sync_out & s_rise[S_FSYNC]; // R9
  wire sync_hit = ssync_hit | fsync_hit;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pos_r <= 9'h000;
      frame_r <= 4'h0;
      sync_pend_r <= 1'b0;
    end
    else
    begin
      sync_pend_r <= sync_hit | (sync_pend_r & ~tx_rise);
      if (tx_rise)
      begin
        if (sync_pend_r | sync_hit)
        begin
          pos_r <= 9'h000; // R3
          if (sync_mf)
            frame_r <= 4'h0; // R9
        end
        else if (pos_r >= frame_last)
        begin
          pos_r <= 9'h000;
          frame_r <= (frame_r >= mf_last) ? 4'h0 : frame_r + 4'h1;
        end
        else
          pos_r <= pos_r + 9'h001;
      end
    end
  end

  // transmit serial capture
  reg [7:0] shift_r;
  reg [7:0] tx_byte_r;
  wire sig_slot = e1 ? (chan == `E1_SIG_CHANNEL) : (sig_frame & lsb);
  wire tx_bit = (sig_en & sig_slot) ? s_lvl[S_SIG] : s_lvl[S_SER]; // R11
  wire [7:0] shift_nxt = {shift_r[6:0], tx_bit};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift_r <= 8'h00;
      tx_byte_r <= 8'h00;
    end
    else if (tx_fall & ~fbit)
    begin
      shift_r <= shift_nxt; // R1
      if (lsb)
        tx_byte_r <= shift_nxt;
    end
  end

  // transmit framer outputs
  reg frac_on_r;
  wire fs_frame = (pos_r == 9'h000) | (double_wide_sync_select & ~e1 & sig_frame & (pos_r == 9'h001));
  wire fs_pulse = sync_mf ? ((frame_r == 4'h0) & (pos_r == 9'h000)) : fs_frame;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_channel_block <= 1'b0;
      tx_channel_clock <= 1'b0;
      tx_frame_sync_out <= 1'b0;
      tx_frame_sync_oe <= 1'b0;
      frac_on_r <= 1'b0;
    end
    else
    begin
      tx_frame_sync_oe <= sync_out; // R9
      if (tx_rise)
      begin
        tx_channel_block <= ~fbit & block_mask_r[chan]; // R6
        frac_on_r <= ~fbit & frac_mask_r[chan];
        tx_frame_sync_out <= sync_out & fs_pulse; // R10
      end
      if (gated)
        tx_channel_clock <= frac_on_r & tx_clk_lvl; // R8
      else if (tx_rise)
        tx_channel_clock <= lsb; // R7
    end
  end

  // mapper transmit serializer
  reg [2:0] map_bit_r;
  reg [9:0] map_byte_r;
  reg [7:0] map_shift_r;
  reg map_sync_pend_r;
  wire map_rise = s_rise[S_MAPCLK];
  wire map_sync = map_sync_pend_r | s_rise[S_BSYNC];
  wire map_mine = (map_byte_r[1:0] == slot);
  // at a sync the slot is channel 1 unless the byte count keeps running
  wire map_first_mine = x86 ? map_mine : (slot == 2'h0);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      map_bit_r <= 3'h0;
      map_byte_r <= 10'h000;
      map_shift_r <= 8'h00;
      map_sync_pend_r <= 1'b0;
      mapper_tx_serial_out <= 1'b0;
    end
    else
    begin
      map_sync_pend_r <= s_rise[S_BSYNC] | (map_sync_pend_r & ~map_rise);
      if (map_rise)
      begin
        if (map_sync)
        begin
          map_bit_r <= 3'h1; // R13
          if (~x86)
            map_byte_r <= 10'h000; // R14
          map_shift_r <= {(map_first_mine ? tx_byte_r[6:0] : 7'h00), 1'b0}; // R13
          mapper_tx_serial_out <= map_first_mine & tx_byte_r[7]; // R12
        end
        else
        begin
          map_bit_r <= map_bit_r + 3'h1;
          if (map_bit_r == 3'h7)
            map_byte_r <= (map_byte_r == `MAP_BYTE_LAST) ? 10'h000 : map_byte_r + 10'h001;
          if (map_bit_r == 3'h0)
          begin
            map_shift_r <= {(map_mine ? tx_byte_r[6:0] : 7'h00), 1'b0};
            mapper_tx_serial_out <= map_mine & tx_byte_r[7]; // R12
          end
          else
          begin
            map_shift_r <= {map_shift_r[6:0], 1'b0};
            mapper_tx_serial_out <= map_shift_r[7]; // R12
          end
        end
      end
    end
  end

  // receive serializer fed from the two-entry buffer
  reg [2:0] rx_bit_r;
  reg [7:0] rx_shift_r;
  wire buf_valid;
  wire [7:0] buf_data;
  wire rx_tick = rx_es ? s_rise[S_RXCLK] : s_rise[S_LCLK]; // R19
  wire rx_load = rx_tick & (rx_bit_r == 3'h0);
  wire rx_pop = rx_load & buf_valid;
  wire underrun_set = rx_load & ~buf_valid;

  byte_buffer2 u_rx_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(rx_byte_valid),
    .in_ready(rx_byte_ready),
    .in_data(rx_byte_data),
    .out_valid(buf_valid),
    .out_ready(rx_pop),
    .out_data(buf_data)
  );

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_bit_r <= 3'h0;
      rx_shift_r <= 8'h00;
      rx_serial_out <= 1'b1;
    end
    else if (rx_tick)
    begin
      rx_bit_r <= rx_bit_r + 3'h1;
      if (rx_bit_r == 3'h0)
      begin
        rx_shift_r <= buf_valid ? {buf_data[6:0], 1'b0} : `RX_IDLE_BYTE;
        rx_serial_out <= buf_valid ? buf_data[7] : 1'b1; // R15
      end
      else
      begin
        rx_shift_r <= {rx_shift_r[6:0], 1'b0};
        rx_serial_out <= rx_shift_r[7]; // R15
      end
    end
  end

  // register port
  wire wr_ctrl = reg_wr & (reg_addr == `ADDR_CTRL);
  wire wr_status = reg_wr & (reg_addr == `ADDR_STATUS);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= `CTRL_RESET;
      block_mask_r <= `MASK_RESET;
      frac_mask_r <= `MASK_RESET;
      underrun_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata[`CTRL_WIDTH-1:0]; // R19
      if (reg_wr & (reg_addr == `ADDR_BLOCK))
        block_mask_r <= reg_wdata; // R6
      if (reg_wr & (reg_addr == `ADDR_FRAC))
        frac_mask_r <= reg_wdata;
      // a new underrun wins over a clear in the same cycle
      if (underrun_set)
        underrun_r <= 1'b1;
      else if (wr_status & reg_wdata[`STAT_UNDERRUN])
        underrun_r <= 1'b0;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_CTRL: reg_rdata <= {21'h000000, ctrl_r};
        `ADDR_BLOCK: reg_rdata <= block_mask_r;
        `ADDR_FRAC: reg_rdata <= frac_mask_r;
        `ADDR_STATUS: reg_rdata <= {3'h0, pos_r, frame_r, 3'h0, chan, 7'h00, underrun_r};
        `ADDR_TXBYTE: reg_rdata <= {24'h000000, tx_byte_r};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end
endmodule // tdm_system_side_interface

// ### tb/tdm_sys_sva.sv
// Purpose: port checker of the system-side interface
// Assumes: serial clocks run at eight clk periods
// Notes: bound to the top module below
`timescale 1ns/1ns
module tdm_sys_sva (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // serial clocks
  input wire tx_line_clock,
  input wire tx_system_clock,
  input wire mapper_tx_clock,
  input wire rx_system_clock,
  // outputs and buffer
  input wire tx_channel_block,
  input wire tx_channel_clock,
  input wire tx_frame_sync_out,
  input wire tx_frame_sync_oe,
  input wire mapper_tx_serial_out,
  input wire rx_serial_out,
  input wire rx_byte_valid,
  input wire rx_byte_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle_low: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_oe_from_ctrl: assert property (reg_wr && reg_addr == 8'h00 |-> ##3 tx_frame_sync_oe == $past(reg_wdata[4], 3))
    else $error("sync enable wrong");
  a_rx_idle_high: assert property ($fell(rst) |-> rx_serial_out)
    else $error("receive data not idle");
  a_mapper_launch: assert property ($changed(mapper_tx_serial_out) |-> $past(mapper_tx_clock, 3))
    else $error("mapper bit off rising edge");
  a_rx_launch: assert property ($changed(rx_serial_out) |-> $past(rx_system_clock, 3) || $past(tx_line_clock, 3))
    else $error("receive bit off rising edge");
  a_block_launch: assert property ($changed(tx_channel_block) |-> $past(tx_line_clock, 3) || $past(tx_system_clock, 3))
    else $error("block off rising edge");
  a_sync_one_bit: assert property ($rose(tx_frame_sync_out) |=> tx_frame_sync_out [*6])
    else $error("sync pulse too short");
  a_ready_after_push: assert property ($fell(rx_byte_ready) |-> $past(rx_byte_valid) || $past(rx_byte_valid, 2))
    else $error("buffer full without push");
  c_chclk: cover property ($rose(tx_channel_clock));
  c_full: cover property ($fell(rx_byte_ready));
  c_sync: cover property ($rose(tx_frame_sync_out));
endmodule // tdm_sys_sva
bind tdm_system_side_interface tdm_sys_sva chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_line_clock(tx_line_clock), .tx_system_clock(tx_system_clock), .mapper_tx_clock(mapper_tx_clock),
  .rx_system_clock(rx_system_clock), .tx_channel_block(tx_channel_block), .tx_channel_clock(tx_channel_clock),
  .tx_frame_sync_out(tx_frame_sync_out), .tx_frame_sync_oe(tx_frame_sync_oe),
  .mapper_tx_serial_out(mapper_tx_serial_out), .rx_serial_out(rx_serial_out),
  .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready));

// ### tb/tdm_far_model.sv
// Purpose: far-side clocks, data and syncs for the system-side interface
// Assumes: 800 ns serial clocks, phases unrelated to clk
// Notes: an unused transmit clock stands still
`timescale 1ns/1ns
module tdm_far_model (
  // bench control
  input wire tx_es,
  input wire tx_level,
  // transmit framer pins
  output reg tx_line_clock,
  output reg tx_system_clock,
  output reg tx_serial_in,
  output reg tx_signaling_in,
  output wire tx_system_sync,
  // mapper and receive pins
  output reg mapper_tx_clock,
  output wire mapper_tx_byte_sync,
  output reg rx_system_clock
);
  reg [3:0] sync_cnt_r = 4'h0;
  reg [9:0] byte_cnt_r = 10'h000;
  initial
  begin
    {tx_line_clock, tx_system_clock, mapper_tx_clock, rx_system_clock} = 4'h0;
    {tx_serial_in, tx_signaling_in} = 2'h0;
  end
  always #400 tx_line_clock = ~tx_line_clock & ~tx_es;
  // fixed phase offsets keep the system, mapper and receive clock edges away from the clk edges
  initial
  fork
    #23 forever #400 tx_system_clock = ~tx_system_clock & tx_es;
    #61 forever #400 mapper_tx_clock = ~mapper_tx_clock;
    #137 forever #400 rx_system_clock = ~rx_system_clock;
  join
  // data launched on rising edges so falling-edge sampling sees it settled
  always @(posedge tx_line_clock or posedge tx_system_clock)
  begin
    tx_serial_in <= tx_level;
    tx_signaling_in <= ~tx_level;
  end
  always @(posedge tx_system_clock or negedge tx_es)
    if (!tx_es)
      sync_cnt_r <= 4'h0;
    else if (sync_cnt_r != 4'hF)
      sync_cnt_r <= sync_cnt_r + 4'h1;
  assign tx_system_sync = tx_es & (sync_cnt_r == 4'h1);
  always @(posedge mapper_tx_clock)
    byte_cnt_r <= byte_cnt_r + 10'h001;
  assign mapper_tx_byte_sync = (byte_cnt_r == 10'h000);
endmodule // tdm_far_model

// ### tb/testbench.sv
// Purpose: self-checking bench of the system-side interface
// Assumes: far-side model supplies 800 ns serial clocks
// Notes: output counts span whole frame periods
`timescale 1ns/1ns
`include "tdm_sys_consts.vh"
`define CHK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin err_total = err_total + 1; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg rx_byte_valid = 1'b0;
  reg [7:0] rx_byte_data = 8'h00;
  reg tx_es = 1'b0;
  reg tx_level = 1'b1;
  wire [31:0] reg_rdata;
  wire tx_line_clock, tx_system_clock, tx_serial_in, tx_signaling_in, tx_system_sync, tx_frame_sync_oe;
  wire mapper_tx_clock, mapper_tx_byte_sync, rx_system_clock, rx_byte_ready, tx_frame_sync_out;
  wire tx_channel_block, tx_channel_clock, mapper_tx_serial_out, rx_serial_out;
  // two-way sync pin with a pull-down
  wire tx_frame_sync_in = tx_frame_sync_oe ? tx_frame_sync_out : 1'b0;
  integer err_total = 0;
  integer tests_run = 0;
  integer hi [0:3];
  integer rises, prev, i, k;
  reg [31:0] rd_val;
  reg [23:0] shift_r;
  always #50 clk = ~clk;
  tdm_system_side_interface uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_line_clock(tx_line_clock),
    .tx_system_clock(tx_system_clock), .tx_serial_in(tx_serial_in), .tx_signaling_in(tx_signaling_in),
    .tx_system_sync(tx_system_sync), .tx_channel_block(tx_channel_block), .tx_channel_clock(tx_channel_clock),
    .tx_frame_sync_in(tx_frame_sync_in), .tx_frame_sync_out(tx_frame_sync_out),
    .tx_frame_sync_oe(tx_frame_sync_oe), .mapper_tx_clock(mapper_tx_clock),
    .mapper_tx_byte_sync(mapper_tx_byte_sync), .mapper_tx_serial_out(mapper_tx_serial_out),
    .rx_system_clock(rx_system_clock), .rx_serial_out(rx_serial_out), .rx_byte_valid(rx_byte_valid),
    .rx_byte_ready(rx_byte_ready), .rx_byte_data(rx_byte_data));
  tdm_far_model far (.tx_es(tx_es), .tx_level(tx_level), .tx_line_clock(tx_line_clock),
    .tx_system_clock(tx_system_clock), .tx_serial_in(tx_serial_in), .tx_signaling_in(tx_signaling_in),
    .tx_system_sync(tx_system_sync), .mapper_tx_clock(mapper_tx_clock),
    .mapper_tx_byte_sync(mapper_tx_byte_sync), .rx_system_clock(rx_system_clock));
  task give_verdict;
  begin
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  end
  endtask
  // settle, then count high cycles of four outputs and channel clock pulses
  task measure(input integer n);
  begin
    repeat (2100) @(posedge clk);
    hi[0] = 0; hi[1] = 0; hi[2] = 0; hi[3] = 0; rises = 0; prev = 1;
    for (i = 0; i < n; i = i + 1)
    begin
      @(posedge clk);
      #1;
      hi[0] = hi[0] + tx_channel_clock;
      hi[1] = hi[1] + tx_channel_block;
      hi[2] = hi[2] + tx_frame_sync_out;
      hi[3] = hi[3] + mapper_tx_serial_out;
      rises = rises + (tx_channel_clock & !prev);
      prev = tx_channel_clock;
    end
  end
  endtask
  task push(input [7:0] d);
  begin
    rx_byte_data <= d;
    rx_byte_valid <= 1'b1;
    k = 0;
    @(posedge clk);
    while (rx_byte_ready !== 1'b1 && k < 200)
    begin
      @(posedge clk);
      k = k + 1;
    end
    if (k == 200)
    begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  endtask
  task s_reset;
  begin
    `CHK(rx_serial_out, 1'b1)
    `CHK(tx_frame_sync_oe, 1'b0)
    rd(`ADDR_CTRL);
    `CHK(rd_val, 32'h0)
    rd(8'h20);
    `CHK(rd_val, 32'h0)
    wr(`ADDR_CTRL, 32'h0000_0654);
    rd(`ADDR_CTRL);
    `CHK(rd_val, 32'h0000_0654)
  end
  endtask
  task s_frames;
  begin
    wr(`ADDR_CTRL, 32'h0000_0010);
    wr(`ADDR_BLOCK, 32'h0000_0001);
    measure(1544);
    `CHK(rises, 24)
    `CHK(hi[0], 192)
    `CHK(hi[1], 64)
    `CHK(hi[2], 8)
    `CHK(tx_frame_sync_oe, 1'b1)
    wr(`ADDR_CTRL, 32'h0000_0114);
    wr(`ADDR_BLOCK, 32'hFFFF_FFFF);
    measure(2048);
    `CHK(rises, 32)
    `CHK(hi[1], 2048)
    `CHK(hi[2], 8)
    `CHK(hi[3], 512)
    rd(`ADDR_TXBYTE);
    `CHK(rd_val, 32'h0000_00FF)
  end
  endtask
  task s_gated;
  begin
    wr(`ADDR_CTRL, 32'h0000_001C);
    wr(`ADDR_FRAC, 32'h0);
    measure(2048);
    `CHK(hi[0], 0)
    wr(`ADDR_FRAC, 32'hFFFF_FFFF);
    measure(2048);
    `CHK(hi[0], 1024)
    wr(`ADDR_CTRL, 32'h0000_0050);
    measure(18528);
    `CHK(hi[2], 112)
  end
  endtask
  task s_elastic;
  begin
    @(posedge clk);
    tx_es <= 1'b1;
    tx_level <= 1'b0;
    wr(`ADDR_CTRL, 32'h0000_0001);
    measure(1544);
    `CHK(rises, 24)
    rd(`ADDR_TXBYTE);
    `CHK(rd_val, 32'h0)
    // signaling reaches only the channel LSBs of two frames per multiframe
    wr(`ADDR_CTRL, 32'h0000_0081);
    for (k = 0; k < 10000 && rd_val !== 32'h0000_0001; k = k + 1)
      rd(`ADDR_TXBYTE);
    `CHK(rd_val, 32'h0000_0001)
  end
  endtask
  task s_receive;
  begin
    wr(`ADDR_CTRL, 32'h0000_0002);
    repeat (200) @(posedge clk);
    rd(`ADDR_STATUS);
    `CHK(rd_val[0], 1'b1)
    @(posedge clk);
    fork
      begin
        push(8'hA5);
        push(8'h3C);
        push(8'h5A);
        rx_byte_valid <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(rx_byte_ready, 1'b0)
      end
      begin
        shift_r = 24'hFFFFFF;
        for (i = 0; i < 400 && shift_r !== 24'hA53C5A; i = i + 1)
        begin
          @(posedge rx_system_clock);
          shift_r = {shift_r[22:0], rx_serial_out};
        end
        `CHK(shift_r, 24'hA53C5A)
      end
    join
  end
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    s_reset;
    s_frames;
    s_gated;
    s_elastic;
    s_receive;
    give_verdict;
  end
endmodule // testbench
